// file: hdl/nbsp_pkg.sv
`default_nettype none
package nbsp_pkg;

  // register byte addresses on the apb bus
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_BUF   = 8'h04;
  localparam logic [7:0] ADDR_BAUD  = 8'h08;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET  = 8'h00;
  localparam logic [1:0] BAUD_RESET = 2'h0;

  // oscillator periods per machine cycle
  localparam int         MC_CYCLES    = 12;
  // oscillator periods per x16 tick in the fixed-rate mode (16 * 2 = 32, 16 * 4 = 64)
  localparam int         FIX_DIV_FAST = 2;
  localparam int         FIX_DIV_SLOW = 4;

  // divide-by-16 counter states (0 based: 7th, 8th, 9th state)
  localparam logic [3:0] DIV_LAST     = 4'hF;
  localparam logic [3:0] SMP_FIRST    = 4'h6;
  localparam logic [3:0] SMP_LAST     = 4'h8;
  localparam logic [3:0] SMP_DECIDE   = 4'h9;

  // rollover index of the stop bit on transmit (10th and 11th rollover)
  localparam logic [3:0] TX_LAST_8    = 4'h9;
  localparam logic [3:0] TX_LAST_9    = 4'hA;
  // receive bit index of the final shift (start = 0)
  localparam logic [3:0] RX_LAST      = 4'h9;

  typedef enum logic [1:0] {
    MODE_SHIFT,
    MODE_UART8,
    MODE_UART9_FIXED,
    MODE_UART9_VAR
  } nbsp_mode_t;

  typedef struct packed {
    nbsp_mode_t mode;
    logic       multiprocessor_enable;
    logic       rx_enable;
    logic       tx_ninth_bit;
    logic       rx_ninth_bit;
    logic       transmit_complete_flag;
    logic       receive_flag;
  } nbsp_ctrl_t;

  typedef struct packed {
    logic src_brg;
    logic baud_double;
  } nbsp_baud_t;

endpackage
`default_nettype wire

// file: hdl/nbsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module nbsp_sync (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic din,
  output var  logic dout
);
  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;

  // three stages, change accepted when the last two agree
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ff1_reg <= 1'b1;
      ff2_reg <= 1'b1;
      ff3_reg <= 1'b1;
      dout    <= 1'b1;
    end else begin
      ff1_reg <= din;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      if (ff2_reg == ff3_reg) begin
        dout <= ff3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/nbsp_vote.sv
`timescale 1ns/1ps
`default_nettype none
module nbsp_vote (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic sample_en,
  input  wire logic din,
  output var  logic vote
);
  logic [2:0] smp_reg;

  // last three samples of the line
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      smp_reg <= 3'h7;
    end else if (sample_en) begin
      smp_reg <= {smp_reg[1:0], din};
    end
  end

  // two of three
  always_comb begin
    vote = (smp_reg[0] & smp_reg[1]) | (smp_reg[1] & smp_reg[2]) | (smp_reg[0] & smp_reg[2]);
  end
endmodule
`default_nettype wire

// file: hdl/nbsp_serial_port.sv
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module nbsp_serial_port
  import nbsp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        t1_overflow_tick,
  input  wire logic        brg_tick,
  input  wire logic        rxd_pin,
  output var  logic        txd_pin
);

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_BITS,
    RX_STOP
  } nbsp_rx_state_t;

  nbsp_ctrl_t     ctrl_reg;
  nbsp_ctrl_t     ctrl_wdata;
  nbsp_baud_t     baud_reg;
  logic [7:0]     rx_buf_reg;
  logic           pready_reg;
  logic           access;
  logic           wr_fire;
  logic           wr_ctrl;
  logic           wr_buf;
  logic           mapped;
  logic [3:0]     mc_cnt_reg;
  logic           state1_phase1;
  logic [1:0]     fix_cnt_reg;
  logic           fix_tick;
  logic           var_half_reg;
  logic           var_src;
  logic           var_tick;
  logic           uart_mode;
  logic           nine_bit;
  logic           tick16;
  logic [3:0]     tx_div_reg;
  logic           tx_roll;
  logic [8:0]     tx_shift_reg;
  logic           tx_busy_reg;
  logic           tx_pend_reg;
  logic [3:0]     tx_cnt_reg;
  logic [3:0]     tx_last;
  logic           tx_step;
  logic           tx_done;
  logic           rxd_s;
  logic           rxd_prev_reg;
  logic           rx_fall;
  nbsp_rx_state_t rx_state_reg;
  logic [3:0]     rx_div_reg;
  logic [3:0]     rx_cnt_reg;
  logic [8:0]     rx_shift_reg;
  logic [8:0]     rx_frame;
  logic           rx_vote;
  logic           rx_sample;
  logic           rx_decide;
  logic           rx_final;
  logic           rx_accept;
  logic           rx_start_edge;

  // apb decode, one wait state per transfer
  always_comb begin
    access     = psel & penable & pready_reg;
    wr_fire    = access & pwrite;
    wr_ctrl    = wr_fire & (paddr == ADDR_CTRL);
    wr_buf     = wr_fire & (paddr == ADDR_BUF);
    mapped     = (paddr == ADDR_CTRL) | (paddr == ADDR_BUF) | (paddr == ADDR_BAUD);
    ctrl_wdata = nbsp_ctrl_t'(pwdata[7:0]);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready_reg <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h0000_0000;
    end else begin
      pready_reg <= psel & penable & ~pready_reg;
      pslverr    <= psel & penable & ~pready_reg & ~mapped;
      if (psel & penable & ~pready_reg & ~pwrite) begin
        case (paddr)
          ADDR_CTRL: prdata <= {24'h00_0000, ctrl_reg};
          ADDR_BUF:  prdata <= {24'h00_0000, rx_buf_reg};
          ADDR_BAUD: prdata <= {30'h0000_0000, baud_reg};
          default:   prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_comb begin
    pready = pready_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      baud_reg <= nbsp_baud_t'(BAUD_RESET);
    end else if (wr_fire & (paddr == ADDR_BAUD)) begin
      baud_reg <= nbsp_baud_t'(pwdata[1:0]);
    end
  end

  // control register; hardware set wins over software clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg <= nbsp_ctrl_t'(CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= ctrl_wdata;
      end
      if (tx_done) begin
        ctrl_reg.transmit_complete_flag <= 1'b1;
      end
      if (rx_accept) begin
        ctrl_reg.receive_flag <= 1'b1;
        ctrl_reg.rx_ninth_bit <= rx_vote;
      end
    end
  end

  // machine cycle, count 0 is state1_phase1
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      mc_cnt_reg <= 4'h0;
    end else if (mc_cnt_reg == 4'(MC_CYCLES - 1)) begin
      mc_cnt_reg <= 4'h0;
    end else begin
      mc_cnt_reg <= mc_cnt_reg + 4'h1;
    end
  end

  // baud clock sources
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      fix_cnt_reg  <= 2'h0;
      var_half_reg <= 1'b0;
    end else begin
      fix_cnt_reg <= fix_tick ? 2'h0 : fix_cnt_reg + 2'h1;
      if (var_src) begin
        var_half_reg <= ~var_half_reg;
      end
    end
  end

  always_comb begin
    state1_phase1      = (mc_cnt_reg == 4'h0);
    uart_mode = (ctrl_reg.mode != MODE_SHIFT);
    nine_bit  = (ctrl_reg.mode == MODE_UART9_FIXED) | (ctrl_reg.mode == MODE_UART9_VAR);
    fix_tick  = baud_reg.baud_double ? (fix_cnt_reg == 2'(FIX_DIV_FAST - 1))
                                     : (fix_cnt_reg == 2'(FIX_DIV_SLOW - 1));
    var_src   = baud_reg.src_brg ? brg_tick : t1_overflow_tick;
    var_tick  = var_src & (baud_reg.baud_double | var_half_reg);
    if (ctrl_reg.mode == MODE_UART9_FIXED) begin
      tick16 = fix_tick;
    end else begin
      tick16 = uart_mode & var_tick;
    end
    tx_roll = tick16 & (tx_div_reg == DIV_LAST);
    tx_last = nine_bit ? TX_LAST_9 : TX_LAST_8;
    tx_step = tx_pend_reg & state1_phase1;
    tx_done = tx_step & (tx_cnt_reg == tx_last);
  end

  // transmitter
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_div_reg <= 4'h0;
    end else if (tick16) begin
      tx_div_reg <= tx_div_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_shift_reg <= 9'h1FF;
      tx_busy_reg  <= 1'b0;
      tx_pend_reg  <= 1'b0;
      tx_cnt_reg   <= 4'h0;
      txd_pin      <= 1'b1;
    end else if (wr_buf) begin
      tx_shift_reg <= {ctrl_reg.tx_ninth_bit, pwdata[7:0]};
      tx_busy_reg  <= 1'b1;
      tx_pend_reg  <= 1'b0;
      tx_cnt_reg   <= 4'h0;
    end else begin
      if (tx_roll & tx_busy_reg) begin
        tx_pend_reg <= 1'b1;
      end else if (tx_step) begin
        tx_pend_reg <= 1'b0;
      end
      if (tx_step) begin
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
        if (tx_cnt_reg == 4'h0) begin
          txd_pin <= 1'b0;
        end else if (tx_done) begin
          txd_pin     <= 1'b1;
          tx_busy_reg <= 1'b0;
        end else begin
          txd_pin      <= tx_shift_reg[0];
          tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
        end
      end
    end
  end

  // receiver
  nbsp_sync u_rx_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .din      (rxd_pin),
    .dout     (rxd_s)
  );

  nbsp_vote u_rx_vote (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .sample_en (rx_sample),
    .din       (rxd_s),
    .vote      (rx_vote)
  );

  always_comb begin
    rx_fall       = rxd_prev_reg & ~rxd_s;
    rx_start_edge = (rx_state_reg == RX_IDLE) & rx_fall & ctrl_reg.rx_enable & uart_mode;
    rx_sample     = tick16 & (rx_state_reg == RX_BITS)
                    & (rx_div_reg >= SMP_FIRST) & (rx_div_reg <= SMP_LAST);
    rx_decide     = tick16 & (rx_state_reg == RX_BITS) & (rx_div_reg == SMP_DECIDE);
    rx_final      = rx_decide & (rx_cnt_reg == RX_LAST);
    rx_frame      = {rx_vote, rx_shift_reg[8:1]};
    // ninth bit in 9-bit modes, stop bit in the 8-bit mode
    rx_accept     = rx_final & ~ctrl_reg.receive_flag
                    & (~ctrl_reg.multiprocessor_enable | rx_vote);
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxd_prev_reg <= 1'b1;
    end else begin
      rxd_prev_reg <= rxd_s;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_div_reg <= 4'h0;
    end else if (rx_start_edge) begin
      rx_div_reg <= 4'h0;
    end else if (tick16) begin
      rx_div_reg <= rx_div_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_cnt_reg <= 4'h0;
          if (rx_start_edge) begin
            rx_state_reg <= RX_BITS;
          end
        end
        RX_BITS: begin
          if (rx_decide) begin
            if (rx_cnt_reg == 4'h0) begin
              if (rx_vote) begin
                rx_state_reg <= RX_IDLE;
              end else begin
                rx_cnt_reg <= 4'h1;
              end
            end else begin
              rx_shift_reg <= rx_frame;
              rx_cnt_reg   <= rx_cnt_reg + 4'h1;
              if (rx_final) begin
                rx_state_reg <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick16 & (rx_div_reg == SMP_DECIDE)) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_buf_reg <= BUF_RESET;
    end else if (rx_accept) begin
      rx_buf_reg <= rx_frame[7:0];
    end
  end
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence s_false_start;
    rx_decide && (rx_cnt_reg == 4'h0) && rx_vote;
  endsequence
  fixed_rate_a: assert property ((ctrl_reg.mode == MODE_UART9_FIXED)
    && tick16 && baud_reg.baud_double && !wr_fire ##1 !wr_fire
    |-> !tick16 ##1 tick16) else $error("fixed rate tick spacing wrong");
  var_source_a: assert property (uart_mode && (ctrl_reg.mode != MODE_UART9_FIXED)
    && baud_reg.src_brg && baud_reg.baud_double && brg_tick |-> tick16) else $error("tick lost");
  var_select_a: assert property ((ctrl_reg.mode == MODE_UART9_VAR)
    && !baud_reg.src_brg && brg_tick && !t1_overflow_tick |-> !tick16) else $error("bad source");
  tx_load_a: assert property (wr_buf |=> tx_busy_reg && (tx_cnt_reg == 4'h0)
    && (tx_shift_reg[8] == $past(ctrl_reg.tx_ninth_bit))) else $error("transmit load wrong");
  tx_align_a: assert property ($changed(txd_pin) |-> $past(mc_cnt_reg) == 4'h0)
    else $error("transmit edge not at machine cycle start");
  tx_stop_a: assert property (tx_done && !wr_buf |=> txd_pin && !tx_busy_reg
    && ctrl_reg.transmit_complete_flag) else $error("stop bit or complete flag missing");
  rx_edge_a: assert property (rx_start_edge |=> (rx_div_reg == 4'h0)
    && (rx_state_reg == RX_BITS)) else $error("divider not reset on start edge");
  rx_reject_a: assert property (s_false_start |=> rx_state_reg == RX_IDLE)
    else $error("false start not rejected");
  rx_accept_a: assert property (rx_accept |=> ctrl_reg.receive_flag
    && (rx_buf_reg == $past(rx_frame[7:0])) && (ctrl_reg.rx_ninth_bit == $past(rx_vote)))
    else $error("accepted frame not stored");
  rx_discard_a: assert property (rx_final && !rx_accept && !wr_ctrl
    |=> $stable(rx_buf_reg) && $stable(ctrl_reg.rx_ninth_bit)) else $error("frame not discarded");
  rx_final_a: assert property (rx_final |=> rx_state_reg == RX_STOP)
    else $error("no stop wait after final shift");
  flag_hold_a: assert property (ctrl_reg.receive_flag && !wr_ctrl
    |=> ctrl_reg.receive_flag) else $error("receive flag dropped by hardware");
  stop_wait_a: assert property ((rx_state_reg == RX_STOP) && nine_bit && !wr_ctrl
    |=> $stable(rx_buf_reg) && $stable(ctrl_reg.rx_ninth_bit) && $stable(ctrl_reg.receive_flag))
    else $error("stop bit changed receive state");
endmodule
`default_nettype wire

// file: testbench/nbsp_peer.sv
`timescale 1ns/1ps
`default_nettype none
module nbsp_peer (
  input  wire logic core_clk,
  input  wire logic txd_pin,
  output var  logic rxd_pin
);
  initial rxd_pin = 1'b1;

  // one frame lsb first, optional 2-clock flip mid bit g, then one idle bit
  task automatic send(input logic [10:0] f, input int nb, input int g, input int p);
    for (int i = 0; i <= nb; i++) begin
      for (int c = 0; c < p; c++) begin
        @(posedge core_clk);
        rxd_pin <= (i == nb) ? 1'b1 : f[i] ^ (i == g && c >= p/2 - 1 && c <= p/2);
      end
    end
  endtask

  // samples each bit in its middle, start bit first
  task automatic capture(input int p, input int nb, output logic [10:0] f);
    f = '1;
    @(negedge txd_pin);
    repeat (p/2) @(posedge core_clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd_pin;
      repeat (p) @(posedge core_clk);
    end
  endtask
endmodule
`default_nettype wire

// file: testbench/nbsp_serial_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nbsp_serial_port_tb
  import nbsp_pkg::*;
;
  logic        core_clk, rst_b, psel, penable, pwrite, brg_tick, t1_overflow_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, txd_pin, rxd_pin, err_seen;
  logic [10:0] fr;
  int          errors, samples_checked, cyc;

  nbsp_serial_port u_nbsp_serial_port (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .t1_overflow_tick(t1_overflow_tick),
    .brg_tick(brg_tick), .rxd_pin(rxd_pin), .txd_pin(txd_pin));

  nbsp_peer u_nbsp_peer (.core_clk(core_clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic complete_run;
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // baud sources: brg every 3 clocks, timer 1 every 2 clocks; hang limit
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    brg_tick <= (cyc % 3 == 2);
    t1_overflow_tick <= cyc[0];
    if (cyc == 60000) begin
      errors = errors + 1;
      complete_run;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer; read data and error taken with pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // control write: flags cleared, receiver on
  task automatic cfg(input nbsp_mode_t m, input logic mp, input logic t9);
    nbsp_ctrl_t c;
    c = '0;
    c.mode = m;
    c.multiprocessor_enable = mp;
    c.rx_enable = 1'b1;
    c.tx_ninth_bit = t9;
    apb(1'b1, ADDR_CTRL, {24'h0, c});
  endtask

  task automatic tx(input nbsp_mode_t m, input logic t9, input logic [7:0] d, input int p);
    int nb;
    nb = (m == MODE_UART8) ? 10 : 11;
    cfg(m, 1'b0, t9);
    fork
      u_nbsp_peer.capture(p, nb, fr);
      apb(1'b1, ADDR_BUF, {24'h0, d});
    join
    chk({21'h0, fr}, (m == MODE_UART8) ? {21'h0, 2'b11, d, 1'b0}
                                       : {21'h0, 1'b1, t9, d, 1'b0}, "tx frame");
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd & 32'h3, 32'h2, "tx flag");
  endtask

  // ef = {rx ninth bit, receive flag}
  task automatic rx(input int nb, input logic [7:0] d, input logic b9, input logic st,
                    input int g, input int p, input logic [7:0] eb, input logic [1:0] ef);
    u_nbsp_peer.send({st, b9, d, 1'b0}, nb, g, p);
    apb(1'b0, ADDR_BUF, 32'h0);
    chk(rd, {24'h0, eb}, "rx buffer");
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd & 32'h5, {29'h0, ef[1], 1'b0, ef[0]}, "rx flags");
  endtask

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    brg_tick = 1'b0;
    t1_overflow_tick = 1'b0;
    cyc = 0;
    errors = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, {24'h0, CTRL_RESET}, "ctrl reset");
    apb(1'b0, ADDR_BUF, 32'h0);
    chk(rd, {24'h0, BUF_RESET}, "buf reset");
    apb(1'b0, ADDR_BAUD, 32'h0);
    chk(rd, {30'h0, BAUD_RESET}, "baud reset");
    apb(1'b1, 8'h0C, 32'hFF);
    chk({31'h0, err_seen}, 32'h1, "unmapped write");
    apb(1'b0, 8'h0C, 32'h0);
    chk({rd[30:0], err_seen}, 32'h1, "unmapped read");
    // fixed rate, doubled: 32 clocks a bit
    apb(1'b1, ADDR_BAUD, 32'h1);
    tx(MODE_UART9_FIXED, 1'b1, 8'h55, 32);
    tx(MODE_UART9_FIXED, 1'b0, 8'hA3, 32);
    cfg(MODE_UART9_FIXED, 1'b0, 1'b0);
    rx(11, 8'h3C, 1'b1, 1'b1, -1, 32, 8'h3C, 2'b11);
    rx(11, 8'h99, 1'b0, 1'b1, -1, 32, 8'h3C, 2'b11);
    cfg(MODE_UART9_FIXED, 1'b1, 1'b0);
    rx(11, 8'h77, 1'b0, 1'b1, -1, 32, 8'h3C, 2'b00);
    rx(11, 8'h81, 1'b1, 1'b1, -1, 32, 8'h81, 2'b11);
    cfg(MODE_UART9_FIXED, 1'b0, 1'b0);
    u_nbsp_peer.send(11'h001, 1, 0, 32);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd & 32'h1, 32'h0, "false start");
    rx(11, 8'hE7, 1'b0, 1'b1, 4, 32, 8'hE7, 2'b01);
    cfg(MODE_UART9_FIXED, 1'b0, 1'b0);
    rx(11, 8'h5A, 1'b1, 1'b0, -1, 32, 8'h5A, 2'b11);
    // fixed rate, not doubled: 64 clocks a bit
    apb(1'b1, ADDR_BAUD, 32'h0);
    tx(MODE_UART9_FIXED, 1'b1, 8'hC6, 64);
    // 8-bit frames from baud generator, doubled: 48 clocks a bit
    apb(1'b1, ADDR_BAUD, 32'h3);
    tx(MODE_UART8, 1'b0, 8'h3A, 48);
    cfg(MODE_UART8, 1'b0, 1'b0);
    rx(10, 8'h6B, 1'b1, 1'b1, -1, 48, 8'h6B, 2'b11);
    cfg(MODE_UART8, 1'b1, 1'b0);
    rx(10, 8'h24, 1'b0, 1'b1, -1, 48, 8'h6B, 2'b00);
    // 9-bit variable from timer 1, not doubled: 64 clocks a bit
    apb(1'b1, ADDR_BAUD, 32'h0);
    tx(MODE_UART9_VAR, 1'b1, 8'h0F, 64);
    cfg(MODE_UART9_VAR, 1'b0, 1'b0);
    rx(11, 8'hF0, 1'b0, 1'b1, -1, 64, 8'hF0, 2'b01);
    complete_run;
  end
endmodule
`default_nettype wire
